/* File: dpi_pkg.sv */
// constants and types for the ddr4 channel pin interface
package dpi_pkg;
  localparam int DQ_W      = 64;
  localparam int DQS_W     = 8;
  localparam int RANKS     = 4;
  localparam int RANKS_MIN = 2;
  localparam int MA_W      = 17;
  localparam int BA_W      = 2;
  localparam int BG_W      = 2;
  localparam int BIT_AP    = 10;
  localparam int BIT_BC_N  = 12;
  localparam int BIT_RAS   = 16;
  localparam int BIT_CAS   = 15;
  localparam int BIT_WE    = 14;
  localparam int SYNC_W    = 2;

  // command codes on the request port
  typedef enum logic [3:0] {
    DPI_CMD_NOP  = 4'h0,
    DPI_CMD_ACT  = 4'h1,
    DPI_CMD_RD   = 4'h2,
    DPI_CMD_WR   = 4'h3,
    DPI_CMD_PRE  = 4'h4,
    DPI_CMD_REF  = 4'h5,
    DPI_CMD_MRS  = 4'h6,
    DPI_CMD_ZQ   = 4'h7
  } dpi_cmd_t;

  // link-side states, one-hot
  typedef enum logic [3:0] {
    DPI_ST_IDLE  = 4'h1,
    DPI_ST_CMD   = 4'h2,
    DPI_ST_WDATA = 4'h4,
    DPI_ST_RDATA = 4'h8
  } dpi_state_t;

  // ras#, cas#, we# levels per command (active low codes on a16..a14)
  localparam logic [2:0] RCW_RD  = 3'h5;
  localparam logic [2:0] RCW_WR  = 3'h4;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_ZQ  = 3'h6;
  localparam logic [2:0] RCW_NOP = 3'h7;
endpackage

/* File: dpi_sync.sv */
// two-flop level synchroniser
`timescale 1ns/100ps
module dpi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule // dpi_sync

/* File: dpi_handshake.sv */
// toggle-based event crossing carrying a word held stable by the sender
`timescale 1ns/100ps
module dpi_handshake #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic              dst_pulse,
  output logic      [W-1:0] dst_data
);
  logic         tog_r;
  logic         tog_nxt;
  logic [W-1:0] hold_r;
  logic [W-1:0] hold_nxt;
  logic         ack_s;
  logic         req_s;
  logic         seen_r;
  logic [W-1:0] dout_r;
  logic [W-1:0] dout_nxt;

  // sender waits for the toggle to come back before a new word, so hold_r is stable when sampled
  assign src_busy = tog_r ^ ack_s;

  always_comb
  begin
    tog_nxt  = tog_r;
    hold_nxt = hold_r;
    if (src_valid && !src_busy)
    begin
      tog_nxt  = ~tog_r;
      hold_nxt = src_data;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
    begin
      tog_r  <= 1'b0;
      hold_r <= '0;
    end
    else
    begin
      tog_r  <= tog_nxt;
      hold_r <= hold_nxt;
    end
  end

  dpi_sync #(.W(1)) u_req (.clk(dst_clk), .rst_n(dst_rst_n), .d(tog_r), .q(req_s));
  dpi_sync #(.W(1)) u_ack (.clk(src_clk), .rst_n(src_rst_n), .d(seen_r), .q(ack_s));

  assign dst_pulse = req_s ^ seen_r;
  assign dout_nxt  = dst_pulse ? hold_r : dout_r;

  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
    begin
      seen_r <= 1'b0;
      dout_r <= '0;
    end
    else
    begin
      seen_r <= req_s;
      dout_r <= dout_nxt;
    end
  end

  assign dst_data = dout_r;
endmodule // dpi_handshake

/* File: dpi_channel.sv */
// ddr4 channel pin interface: command, address, rank controls and data pins
`timescale 1ns/100ps
module dpi_channel #(
  parameter bit FULL_RANKS = 1'b1
) (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          link_clk,
  input  wire logic                          link_rst_n,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire dpi_pkg::dpi_cmd_t             req_cmd,
  input  wire logic [1:0]                    req_rank,
  input  wire logic [dpi_pkg::MA_W-1:0]      req_addr,
  input  wire logic [dpi_pkg::BA_W-1:0]      req_bank,
  input  wire logic [dpi_pkg::BG_W-1:0]      req_group,
  input  wire logic                          req_auto_pre,
  input  wire logic                          req_all_banks,
  input  wire logic                          req_burst_chop,
  input  wire logic [dpi_pkg::DQ_W-1:0]      req_wdata,
  output logic                               rd_valid,
  output logic [dpi_pkg::DQ_W-1:0]           rd_data,
  input  wire logic [dpi_pkg::RANKS-1:0]     cke_req,
  input  wire logic [dpi_pkg::RANKS-1:0]     odt_req,
  input  wire logic                          suspend_to_ram_state,
  output logic [dpi_pkg::RANKS-1:0]          mem_clock_true,
  output logic [dpi_pkg::RANKS-1:0]          mem_clock_complement,
  output logic [dpi_pkg::RANKS-1:0]          rank_clock_enable,
  output logic [dpi_pkg::RANKS-1:0]          rank_select_n,
  output logic [dpi_pkg::RANKS-1:0]          rank_termination_ctrl,
  output logic [dpi_pkg::MA_W-1:0]           mux_address_bus,
  output logic                               activation_cmd_line,
  output logic [dpi_pkg::BA_W-1:0]           bank_addr,
  output logic [dpi_pkg::BG_W-1:0]           bank_group,
  input  wire logic [dpi_pkg::DQ_W-1:0]      chan_data_bus_i,
  output logic [dpi_pkg::DQ_W-1:0]           chan_data_bus_o,
  output logic                               chan_data_bus_oe,
  input  wire logic [dpi_pkg::DQS_W-1:0]     strobe_true_i,
  input  wire logic [dpi_pkg::DQS_W-1:0]     strobe_complement_i,
  output logic [dpi_pkg::DQS_W-1:0]          strobe_true_o,
  output logic [dpi_pkg::DQS_W-1:0]          strobe_complement_o,
  output logic                               strobe_oe
);
  import dpi_pkg::*;

  localparam int REQ_W = 4 + 2 + MA_W + BA_W + BG_W + DQ_W;

  // masks a per-rank vector, with the upper ranks masked off in a reduced build
  function automatic logic [RANKS-1:0] rank_mask(input logic [RANKS-1:0] v);
    logic [RANKS-1:0] m;
    m = v;
    if (!FULL_RANKS)
      m[RANKS-1:RANKS_MIN] = '0;
    return m;
  endfunction

  // maps a non-activate command onto ras#, cas#, we# levels
  function automatic logic [2:0] rcw_of(input dpi_cmd_t c);
    logic [2:0] v;
    v = RCW_NOP;
    case (c)
      DPI_CMD_RD:  v = RCW_RD;
      DPI_CMD_WR:  v = RCW_WR;
      DPI_CMD_PRE: v = RCW_PRE;
      DPI_CMD_REF: v = RCW_REF;
      DPI_CMD_MRS: v = RCW_MRS;
      DPI_CMD_ZQ:  v = RCW_ZQ;
      default:     v = RCW_NOP;
    endcase
    return v;
  endfunction

  // core side: pack request, address bits steered by command
  logic [MA_W-1:0]  addr_fmt;
  logic [REQ_W-1:0] req_word;
  logic             hs_busy;

  always_comb
  begin
    addr_fmt = req_addr;
    if (req_cmd == DPI_CMD_RD || req_cmd == DPI_CMD_WR)
    begin
      addr_fmt[BIT_AP]   = req_auto_pre;
      addr_fmt[BIT_BC_N] = ~req_burst_chop;
    end
    if (req_cmd == DPI_CMD_PRE)
      addr_fmt[BIT_AP] = req_all_banks;
  end

  assign req_word  = {req_cmd, req_rank, addr_fmt, req_bank, req_group, req_wdata};
  assign req_ready = !hs_busy;

  logic             lk_pulse;
  logic [REQ_W-1:0] lk_word;

  dpi_handshake #(.W(REQ_W)) u_req_x (
    .src_clk   (mclk),
    .src_rst_n (resetn),
    .src_valid (req_valid),
    .src_data  (req_word),
    .src_busy  (hs_busy),
    .dst_clk   (link_clk),
    .dst_rst_n (link_rst_n),
    .dst_pulse (lk_pulse),
    .dst_data  (lk_word)
  );

  // the crossing registers the word on its pulse, so the word is read one link cycle after the pulse
  dpi_cmd_t         lk_cmd;
  logic [1:0]       lk_rank;
  logic [MA_W-1:0]  lk_addr;
  logic [BA_W-1:0]  lk_bank;
  logic [BG_W-1:0]  lk_group;
  logic [DQ_W-1:0]  lk_wdata;
  assign {lk_cmd, lk_rank, lk_addr, lk_bank, lk_group, lk_wdata} = lk_word;

  // level controls crossing to the link domain
  logic [RANKS-1:0] cke_s;
  logic [RANKS-1:0] odt_s;
  logic             str_s;

  dpi_sync #(.W(RANKS)) u_cke (.clk(link_clk), .rst_n(link_rst_n), .d(cke_req), .q(cke_s));
  dpi_sync #(.W(RANKS)) u_odt (.clk(link_clk), .rst_n(link_rst_n), .d(odt_req), .q(odt_s));
  dpi_sync #(.W(1))     u_str (.clk(link_clk), .rst_n(link_rst_n), .d(suspend_to_ram_state), .q(str_s));

  // link side state
  dpi_state_t      st_r, st_nxt;
  logic [RANKS-1:0] cs_n_r, cs_n_nxt;
  logic [RANKS-1:0] cke_r, cke_nxt;
  logic [RANKS-1:0] odt_r, odt_nxt;
  logic [MA_W-1:0]  ma_r, ma_nxt;
  logic             act_r, act_nxt;
  logic [BA_W-1:0]  ba_r, ba_nxt;
  logic [BG_W-1:0]  bg_r, bg_nxt;
  logic [DQ_W-1:0]  wd_r, wd_nxt;
  logic             dq_oe_r, dq_oe_nxt;
  logic             dqs_oe_r, dqs_oe_nxt;
  logic [DQS_W-1:0] dqs_r, dqs_nxt;
  logic             rd_go_r, rd_go_nxt;
  logic             lk_go_r, lk_go_nxt;

  always_comb
  begin
    st_nxt     = st_r;
    cs_n_nxt   = '1;
    ma_nxt     = ma_r;
    act_nxt    = 1'b1;
    ba_nxt     = ba_r;
    bg_nxt     = bg_r;
    wd_nxt     = wd_r;
    dq_oe_nxt  = 1'b0;
    dqs_oe_nxt = 1'b0;
    dqs_nxt    = '0;
    rd_go_nxt  = 1'b0;
    // delayed pulse lines up with the registered word of the crossing
    lk_go_nxt  = lk_pulse;
    // self-refresh during suspend drops every rank's clock enable
    cke_nxt    = str_s ? '0 : rank_mask(cke_s);
    odt_nxt    = rank_mask(odt_s);
    case (st_r)
      DPI_ST_IDLE:
      begin
        // a command for an absent rank is dropped, so no bus is driven without a select
        if (lk_go_r && lk_cmd != DPI_CMD_NOP && rank_mask(4'h1 << lk_rank) != '0)
        begin
          cs_n_nxt = ~rank_mask(4'h1 << lk_rank);
          ba_nxt   = lk_bank;
          bg_nxt   = lk_group;
          ma_nxt   = lk_addr;
          if (lk_cmd == DPI_CMD_ACT)
            act_nxt = 1'b0;
          else
          begin
            act_nxt = 1'b1;
            ma_nxt[BIT_RAS:BIT_WE] = rcw_of(lk_cmd);
          end
          wd_nxt = lk_wdata;
          if (lk_cmd == DPI_CMD_WR)
            st_nxt = DPI_ST_WDATA;
          else if (lk_cmd == DPI_CMD_RD)
            st_nxt = DPI_ST_RDATA;
          else
            st_nxt = DPI_ST_CMD;
        end
      end
      DPI_ST_CMD:
        st_nxt = DPI_ST_IDLE;
      DPI_ST_WDATA:
      begin
        // drive data with strobe true high and complement low for one cycle, its rising edge aligned with the data enable  
        dq_oe_nxt  = 1'b1;
        dqs_oe_nxt = 1'b1;
        dqs_nxt    = '1;
        st_nxt     = DPI_ST_IDLE;
      end
      DPI_ST_RDATA:
      begin
        rd_go_nxt = 1'b1;
        st_nxt    = DPI_ST_IDLE;
      end
      default:
        st_nxt = DPI_ST_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      st_r     <= DPI_ST_IDLE;
      cs_n_r   <= '1;
      cke_r    <= '0;
      odt_r    <= '0;
      ma_r     <= '0;
      act_r    <= 1'b1;
      ba_r     <= '0;
      bg_r     <= '0;
      wd_r     <= '0;
      dq_oe_r  <= 1'b0;
      dqs_oe_r <= 1'b0;
      dqs_r    <= '0;
      rd_go_r  <= 1'b0;
      lk_go_r  <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      cs_n_r   <= cs_n_nxt;
      cke_r    <= cke_nxt;
      odt_r    <= odt_nxt;
      ma_r     <= ma_nxt;
      act_r    <= act_nxt;
      ba_r     <= ba_nxt;
      bg_r     <= bg_nxt;
      wd_r     <= wd_nxt;
      dq_oe_r  <= dq_oe_nxt;
      dqs_oe_r <= dqs_oe_nxt;
      dqs_r    <= dqs_nxt;
      rd_go_r  <= rd_go_nxt;
      lk_go_r  <= lk_go_nxt;
    end
  end

  // read capture on the strobe crossing: true high with complement low
  // the pin word is registered before it crosses, so the crossing never samples a moving bus
  logic [DQ_W-1:0] rcap_r, rcap_nxt;
  logic            rcap_v_r, rcap_v_nxt;
  logic            strobe_cross;
  assign strobe_cross = &(strobe_true_i & ~strobe_complement_i);
  assign rcap_nxt     = (rd_go_r && strobe_cross) ? chan_data_bus_i : rcap_r;
  assign rcap_v_nxt   = rd_go_r && strobe_cross;

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rcap_r   <= '0;
      rcap_v_r <= 1'b0;
    end
    else
    begin
      rcap_r   <= rcap_nxt;
      rcap_v_r <= rcap_v_nxt;
    end
  end

  dpi_handshake #(.W(DQ_W)) u_rd_x (
    .src_clk   (link_clk),
    .src_rst_n (link_rst_n),
    .src_valid (rcap_v_r),
    .src_data  (rcap_r),
    .src_busy  (),
    .dst_clk   (mclk),
    .dst_rst_n (resetn),
    .dst_pulse (rd_valid),
    .dst_data  (rd_data)
  );

  // memory clock pair per rank follows the link clock; gated off for absent ranks
  assign mem_clock_true        = rank_mask({RANKS{link_clk}});
  assign mem_clock_complement  = rank_mask({RANKS{~link_clk}});
  assign rank_clock_enable     = cke_r;
  assign rank_select_n         = cs_n_r | ~rank_mask('1);
  assign rank_termination_ctrl = odt_r;
  assign mux_address_bus       = ma_r;
  assign activation_cmd_line   = act_r;
  assign bank_addr             = ba_r;
  assign bank_group            = bg_r;
  assign chan_data_bus_o       = wd_r;
  assign chan_data_bus_oe      = dq_oe_r;
  assign strobe_true_o         = dqs_r;
  assign strobe_complement_o   = ~dqs_r;
  assign strobe_oe             = dqs_oe_r;
endmodule // dpi_channel

/* File: dpi_channel_sva.sv */
// assertions on the channel pin interface ports
`timescale 1ns/100ps
module dpi_channel_sva #(
  parameter bit FULL_RANKS = 1'b1
) (
  input wire logic        link_clk,
  input wire logic        link_rst_n,
  input wire logic [3:0]  cke_req,
  input wire logic [3:0]  odt_req,
  input wire logic        suspend_to_ram_state,
  input wire logic [3:0]  rank_clock_enable,
  input wire logic [3:0]  rank_select_n,
  input wire logic [3:0]  rank_termination_ctrl,
  input wire logic [16:0] mux_address_bus,
  input wire logic        activation_cmd_line,
  input wire logic        chan_data_bus_oe,
  input wire logic [7:0]  strobe_true_o,
  input wire logic [7:0]  strobe_complement_o,
  input wire logic        strobe_oe
);
  import dpi_pkg::*;
  logic [3:0] msk;
  logic       is_cmd;
  logic       is_wr;
  logic       is_rd;
  assign msk = FULL_RANKS ? 4'hF : 4'h3;
  assign is_cmd = rank_select_n != 4'hF && activation_cmd_line;
  assign is_wr = is_cmd && mux_address_bus[16:14] == RCW_WR;
  assign is_rd = is_cmd && mux_address_bus[16:14] == RCW_RD;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);
  sequence s_wr_burst;
    is_wr ##1 (chan_data_bus_oe && strobe_oe);
  endsequence
  sequence s_rd_quiet;
    is_rd ##1 !chan_data_bus_oe;
  endsequence
  a_cs_single_cycle: assert property (rank_select_n != 4'hF |=> rank_select_n == 4'hF)
    else $error("chip select held past one cycle");
  a_cs_one_rank: assert property (rank_select_n != 4'hF |-> $onehot(~rank_select_n))
    else $error("more than one rank selected");
  a_cmd_code_legal: assert property (is_cmd |-> mux_address_bus[16:14] != RCW_NOP)
    else $error("selected command carries no command code");
  a_write_drives_next: assert property (is_wr |-> s_wr_burst)
    else $error("write data not driven after write");
  a_oe_after_write: assert property ($rose(chan_data_bus_oe) |-> $past(is_wr))
    else $error("data bus driven without write");
  a_read_no_drive: assert property (is_rd |-> s_rd_quiet)
    else $error("data bus driven during read");
  a_strobe_pair_diff: assert property (strobe_oe |-> chan_data_bus_oe && strobe_true_o == ~strobe_complement_o)
    else $error("strobe pair not complementary");
  a_cke_follows_req: assert property (($stable(cke_req) && !suspend_to_ram_state)[*5]
    |-> rank_clock_enable == (cke_req & msk))
    else $error("clock enable does not follow request");
  a_str_cke_off: assert property (suspend_to_ram_state[*5] |-> rank_clock_enable == 4'h0)
    else $error("clock enable high in suspend");
  a_odt_follows_req: assert property ($stable(odt_req)[*5] |-> rank_termination_ctrl == (odt_req & msk))
    else $error("termination does not follow request");
endmodule // dpi_channel_sva

bind dpi_channel dpi_channel_sva #(.FULL_RANKS(FULL_RANKS)) dpi_channel_sva_inst (
  .link_clk, .link_rst_n, .cke_req, .odt_req, .suspend_to_ram_state, .rank_clock_enable,
  .rank_select_n, .rank_termination_ctrl, .mux_address_bus, .activation_cmd_line,
  .chan_data_bus_oe, .strobe_true_o, .strobe_complement_o, .strobe_oe
);

/* File: dpi_mem_model.sv */
// behavioural sdram ranks at the far side of the channel
`timescale 1ns/100ps
module dpi_mem_model (
  input  wire logic [0:0]  ck,
  input  wire logic [3:0]  cs_n,
  input  wire logic        act_n,
  input  wire logic [16:0] ma,
  input  wire logic [63:0] dq_in,
  input  wire logic        dq_oe,
  input  wire logic [63:0] rd_word,
  output logic [63:0]      dq_drv,
  output logic [7:0]       dqs_t,
  output logic [7:0]       dqs_c,
  output int               cmd_cnt,
  output logic [3:0]       last_cs_n,
  output logic             last_act,
  output logic [16:0]      last_ma,
  output logic [63:0]      wdata
);
  import dpi_pkg::*;
  logic rd_drive = 1'b0;
  logic wr_pend = 1'b0;
  initial cmd_cnt = 0;
  // command sampled where the true clock rises against its falling complement
  always @(posedge ck[0])
  begin
    rd_drive <= 1'b0;
    wr_pend <= 1'b0;
    if (wr_pend && dq_oe === 1'b1)
      wdata <= dq_in;
    if (cs_n != 4'hF)
    begin
      cmd_cnt <= cmd_cnt + 1;
      last_cs_n <= cs_n;
      last_act <= act_n;
      last_ma <= ma;
      rd_drive <= act_n && ma[16:14] == RCW_RD;
      wr_pend <= act_n && ma[16:14] == RCW_WR;
    end
  end
  // a released bus shows the inverse word so stale data cannot pass for a read
  assign dq_drv = rd_drive ? rd_word : ~rd_word;
  assign dqs_t = {8{rd_drive}};
  assign dqs_c = ~dqs_t;
endmodule // dpi_mem_model

/* File: dpi_channel_tb.sv */
// self-checking bench for the ddr4 channel pin interface
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, ex, got); end end
module dpi_channel_tb;
  import dpi_pkg::*;
  logic        mclk = 0, link_clk = 0, resetn = 0, link_rst_n = 0;
  logic        req_valid = 0, req_ready, ap = 0, ab = 0, bc = 0, str = 0, rd_valid, actn, dqoe, soe;
  dpi_cmd_t    req_cmd = DPI_CMD_NOP;
  logic [1:0]  req_rank = '0, ba, bg;
  logic [16:0] req_addr = '0, ma, lma;
  logic [63:0] wd = '0, rw = 64'h0123_4567_89AB_CDEF, rd_data, rd_last, dqi, dqo, mdq, wcap;
  logic [3:0]  cke_req = '0, odt_req = '0, ckt, ckc, cke, csn, odt, lcs, ckr, cker, odtr;
  logic [7:0]  sti, sci, sto, sco, mst, msc;
  logic        lact, rd_hit = 1'b0;
  int          failures = 0, num_checks = 0, cnt, rd_seen = 0;
  assign dqi = dqoe ? dqo : mdq;
  assign sti = soe ? sto : mst;
  assign sci = soe ? sco : msc;
  initial forever #4 mclk = ~mclk;
  initial
  begin
    #3;
    forever #80 link_clk = ~link_clk;
  end
  dpi_channel dpi_channel_inst (.mclk, .resetn, .link_clk, .link_rst_n, .req_valid, .req_ready, .req_cmd,
    .req_rank, .req_addr, .req_bank(2'h1), .req_group(2'h2), .req_auto_pre(ap), .req_all_banks(ab),
    .req_burst_chop(bc), .req_wdata(wd), .rd_valid, .rd_data, .cke_req, .odt_req,
    .suspend_to_ram_state(str), .mem_clock_true(ckt), .mem_clock_complement(ckc), .rank_clock_enable(cke),
    .rank_select_n(csn), .rank_termination_ctrl(odt), .mux_address_bus(ma), .activation_cmd_line(actn),
    .bank_addr(ba), .bank_group(bg), .chan_data_bus_i(dqi), .chan_data_bus_o(dqo), .chan_data_bus_oe(dqoe),
    .strobe_true_i(sti), .strobe_complement_i(sci), .strobe_true_o(sto), .strobe_complement_o(sco),
    .strobe_oe(soe));
  dpi_mem_model dpi_mem_model_inst (.ck(ckt[0]), .cs_n(csn), .act_n(actn), .ma, .dq_in(dqo), .dq_oe(dqoe),
    .rd_word(rw), .dq_drv(mdq), .dqs_t(mst), .dqs_c(msc), .cmd_cnt(cnt), .last_cs_n(lcs), .last_act(lact),
    .last_ma(lma), .wdata(wcap));
  // reduced build shares every input and must keep its upper ranks quiet
  dpi_channel #(.FULL_RANKS(1'b0)) dpi_channel_red_inst (.mclk, .resetn, .link_clk, .link_rst_n, .req_valid,
    .req_ready(), .req_cmd, .req_rank, .req_addr, .req_bank(2'h1), .req_group(2'h2), .req_auto_pre(ap),
    .req_all_banks(ab), .req_burst_chop(bc), .req_wdata(wd), .rd_valid(), .rd_data(), .cke_req, .odt_req,
    .suspend_to_ram_state(str), .mem_clock_true(ckr), .mem_clock_complement(), .rank_clock_enable(cker),
    .rank_select_n(), .rank_termination_ctrl(odtr), .mux_address_bus(), .activation_cmd_line(), .bank_addr(),
    .bank_group(), .chan_data_bus_i(dqi), .chan_data_bus_o(), .chan_data_bus_oe(), .strobe_true_i(sti),
    .strobe_complement_i(sci), .strobe_true_o(), .strobe_complement_o(), .strobe_oe());
  // the read word is registered at the edge that ends its pulse, so take it one cycle later
  always @(posedge mclk)
  begin
    rd_hit <= rd_valid === 1'b1;
    if (rd_hit)
    begin
      rd_seen <= rd_seen + 1;
      rd_last <= rd_data;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic send(dpi_cmd_t c, logic [1:0] r, logic [16:0] a, logic [1:0] f, logic [63:0] w);
    int n;
    int c0;
    c0 = cnt;
    @(posedge mclk);
    req_cmd <= c;
    req_rank <= r;
    req_addr <= a;
    ap <= f[0];
    ab <= f[0];
    bc <= f[1];
    wd <= w;
    req_valid <= 1'b1;
    n = 0;
    do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 300);
    req_valid <= 1'b0;
    n = 0;
    while (cnt == c0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    `CHK("cmd count", 1, cnt - c0)
    // leaves time for write data and the read word to cross back
    repeat (80) @(posedge mclk);
  endtask

  task automatic t_codes();
    dpi_cmd_t   cm[6] = '{DPI_CMD_RD, DPI_CMD_WR, DPI_CMD_PRE, DPI_CMD_REF, DPI_CMD_MRS, DPI_CMD_ZQ};
    logic [2:0] rc[6] = '{3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
    logic [1:0] f;
    int         r0;
    for (int i = 0; i < 12; i++)
    begin
      f = 2'(i / 6 + (i % 2) * 2);
      r0 = rd_seen;
      send(cm[i % 6], 2'(i % 4), 17'h00155, f, {32'(i), 32'hA5C3_0F96});
      `CHK("code", rc[i % 6], lma[16:14])
      `CHK("act line", 1'b1, lact)
      `CHK("rank", ~(4'h1 << (i % 4)), lcs)
      if (i % 6 < 2)
      begin
        `CHK("auto pre", f[0], lma[10])
        `CHK("chop", ~f[1], lma[12])
      end
      if (i % 6 == 2)
        `CHK("all banks", f[0], lma[10])
      if (i % 6 == 1)
        `CHK("wdata", {32'(i), 32'hA5C3_0F96}, wcap)
      if (i % 6 == 0)
      begin
        `CHK("rd count", r0 + 1, rd_seen)
        `CHK("rdata", rw, rd_last)
      end
    end
  endtask

  task automatic t_activate();
    send(DPI_CMD_ACT, 2'h2, 17'h15A5C, 2'h0, '0);
    `CHK("act low", 1'b0, lact)
    `CHK("row", 17'h15A5C, lma)
    `CHK("bank", 2'h1, ba)
    `CHK("group", 2'h2, bg)
  endtask

  task automatic lwait();
    repeat (8) @(posedge link_clk);
    @(posedge mclk);
  endtask

  task automatic t_pins();
    `CHK("ck pair", ~ckt, ckc)
    `CHK("ck red", 2'h0, ckr[3:2])
    cke_req <= 4'hF;
    odt_req <= 4'h5;
    lwait();
    `CHK("cke", 4'hF, cke)
    `CHK("odt", 4'h5, odt)
    `CHK("cke red", 4'h3, cker)
    `CHK("odt red", 4'h1, odtr)
    str <= 1'b1;
    odt_req <= 4'hA;
    lwait();
    `CHK("cke str", 4'h0, cke)
    `CHK("odt2", 4'hA, odt)
    `CHK("odt2 red", 4'h2, odtr)
    str <= 1'b0;
    lwait();
    `CHK("cke back", 4'hF, cke)
    `CHK("cke back red", 4'h3, cker)
  endtask

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    // link flops only take their reset at their own first edge
    repeat (2) @(posedge link_clk);
    @(posedge mclk);
    `CHK("rst cs", 4'hF, csn)
    `CHK("rst cke", 4'h0, cke)
    `CHK("rst oe", 1'b0, dqoe)
    `CHK("rst act", 1'b1, actn)
    repeat (2) @(posedge link_clk);
    link_rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_codes();
    t_activate();
    t_pins();
    report_and_stop();
  end
endmodule // dpi_channel_tb
